// *** core/schs_defines.vh ***
// shared constants for the stop-clock and halt sequencer
`ifndef SCHS_DEFINES_VH
`define SCHS_DEFINES_VH
`define SCHS_ST_W 3
`define SCHS_ST_RUN 3'h0
`define SCHS_ST_HALTED 3'h1
`define SCHS_ST_STOPGNT 3'h2
`define SCHS_ST_INTA 3'h3
`define SCHS_ST_DESC 3'h4
`define SCHS_ST_FETCH 3'h5
`define SCHS_ST_ISR 3'h6
`define SCHS_CYC_W 2
`define SCHS_CYC_HALT 2'h1
`define SCHS_CYC_STOPGNT 2'h2
`define SCHS_INTA_CYCLES 2'h2
`endif

// *** core/schs_cycle_gen.v ***
// special bus cycle issuer: one request becomes one strobe with its code
`timescale 1ns/1ns
`include "schs_defines.vh"
module schs_cycle_gen (
  input wire clock_i,
  input wire rst_i,
  input wire req_i,
  input wire [`SCHS_CYC_W-1:0] code_i,
  output reg cyc_valid_o,
  output reg [`SCHS_CYC_W-1:0] cyc_code_o
);
  always @(posedge clock_i) begin
    if (rst_i) begin
      cyc_valid_o <= 1'b0;
      cyc_code_o <= {`SCHS_CYC_W{1'b0}};
    end else begin
      cyc_valid_o <= req_i;
      if (req_i) begin
        cyc_code_o <= code_i;
      end
    end
  end
endmodule

// *** core/schs_sequencer.v ***
// stop-clock and halt state sequencer
// Summary of operation
// - stop request during resume instruction: finish it, grant cycle, stop
// - resume into halt only with auto halt restart enabled
// - resume into halt issues halt cycle, after stop request drops if no interrupt is pending
// - executing the halt instruction issues a halt cycle
// - interrupt while stop held: stay stopped, no interrupt bus activity
// - stop released with interrupt pending starts the service routine
// - service order: acknowledge cycles, descriptor read, first fetch
// - enabled interrupt when halted or released stop is serviced
// - stop request recognised only at an instruction boundary
`timescale 1ns/1ns
`include "schs_defines.vh"
module schs_sequencer (
  input wire clock_i,
  input wire rst_i,
  input wire stop_clock_request_n_i,
  input wire intr_i,
  input wire int_enable_i,
  input wire auto_halt_restart_i,
  input wire insn_boundary_i,
  input wire halt_instruction_i,
  input wire management_mode_resume_instruction_i,
  input wire resume_to_halt_i,
  input wire bus_done_i,
  output reg inta_cycle_o,
  output reg desc_read_o,
  output reg isr_fetch_o,
  output reg isr_start_o,
  output reg halted_o,
  output reg stop_granted_o,
  output wire special_valid_o,
  output wire [`SCHS_CYC_W-1:0] special_code_o
);
  reg [`SCHS_ST_W-1:0] state_q;
  reg [`SCHS_ST_W-1:0] state_d;
  // halt cycle still owed by a resume into halt that met a stop request
  reg halt_owed_q;
  reg halt_owed_d;
  // counts finished acknowledge cycles
  reg [1:0] inta_cnt_q;
  reg [1:0] inta_cnt_d;
  // one-cycle request into the special cycle register
  reg cyc_req;
  reg [`SCHS_CYC_W-1:0] cyc_code;
  // the request pin is active low
  wire stop_req;
  // a masked interrupt is invisible to the whole machine
  wire irq;

  assign stop_req = ~stop_clock_request_n_i;
  assign irq = intr_i & int_enable_i;

  // shared state compare for the decode and the output flops
  function schs_in_state;
    input [`SCHS_ST_W-1:0] st;
    input [`SCHS_ST_W-1:0] code;
    begin
      schs_in_state = (st == code);
    end
  endfunction

  // resume lands in halt only with the restart option on
  function schs_resume_halts;
    input resume;
    input to_halt;
    input restart_on;
    begin
      schs_resume_halts = resume & to_halt & restart_on;
    end
  endfunction

  // acknowledge phase ends on the last of its fixed bus cycles
  function schs_last_inta;
    input [1:0] cnt;
    begin
      schs_last_inta = (cnt == `SCHS_INTA_CYCLES - 2'h1);
    end
  endfunction

  // leaving stop grant: a pending interrupt wins over an owed halt
  // cycle, which is then dropped rather than issued late
  function [`SCHS_ST_W-1:0] schs_wake_state;
    input irq_pending;
    input halt_owed;
    begin
      if (irq_pending) begin
        schs_wake_state = `SCHS_ST_INTA;
      end else if (halt_owed) begin
        schs_wake_state = `SCHS_ST_HALTED;
      end else begin
        schs_wake_state = `SCHS_ST_RUN;
      end
    end
  endfunction

  always @* begin
    state_d = state_q;
    halt_owed_d = halt_owed_q;
    inta_cnt_d = inta_cnt_q;
    cyc_req = 1'b0;
    cyc_code = `SCHS_CYC_HALT;
    case (state_q)
      `SCHS_ST_RUN: begin
        // only boundaries may act; a resume instruction completes first
        // priority at a boundary: stop, then resume into halt, then interrupt, then halt instruction
        if (insn_boundary_i) begin
          if (schs_resume_halts(management_mode_resume_instruction_i,
              resume_to_halt_i, auto_halt_restart_i)) begin
            if (stop_req) begin
              state_d = `SCHS_ST_STOPGNT;
              halt_owed_d = 1'b1;
              cyc_req = 1'b1;
              cyc_code = `SCHS_CYC_STOPGNT;
            end else begin
              state_d = `SCHS_ST_HALTED;
              cyc_req = 1'b1;
            end
          end else if (stop_req) begin
            state_d = `SCHS_ST_STOPGNT;
            cyc_req = 1'b1;
            cyc_code = `SCHS_CYC_STOPGNT;
          end else if (irq) begin
            state_d = `SCHS_ST_INTA;
            inta_cnt_d = 2'h0;
          end else if (halt_instruction_i) begin
            state_d = `SCHS_ST_HALTED;
            cyc_req = 1'b1;
          end
        end
      end
      `SCHS_ST_HALTED: begin
        // already at a boundary, so a stop request acts at once
        if (stop_req) begin
          state_d = `SCHS_ST_STOPGNT;
          cyc_req = 1'b1;
          cyc_code = `SCHS_CYC_STOPGNT;
        end else if (irq) begin
          state_d = `SCHS_ST_INTA;
          inta_cnt_d = 2'h0;
        end
      end
      `SCHS_ST_STOPGNT: begin
        // held here while requested, whatever interrupts arrive
        if (!stop_req) begin
          state_d = schs_wake_state(irq, halt_owed_q);
          inta_cnt_d = 2'h0;
          halt_owed_d = 1'b0;
          // owed halt cycle goes out only if no interrupt took over
          cyc_req = schs_in_state(state_d, `SCHS_ST_HALTED);
        end
      end
      `SCHS_ST_INTA: begin
        // stop requests wait until the service sequence is over
        if (bus_done_i) begin
          if (schs_last_inta(inta_cnt_q)) begin
            state_d = `SCHS_ST_DESC;
          end else begin
            inta_cnt_d = inta_cnt_q + 2'h1;
          end
        end
      end
      `SCHS_ST_DESC: begin
        // one descriptor read, ended by the bus
        if (bus_done_i) begin
          state_d = `SCHS_ST_FETCH;
        end
      end
      `SCHS_ST_FETCH: begin
        // first routine fetch, ended by the bus
        if (bus_done_i) begin
          state_d = `SCHS_ST_ISR;
        end
      end
      `SCHS_ST_ISR: begin
        // one cycle to mark the start of the routine
        state_d = `SCHS_ST_RUN;
      end
      default: begin
        // unused codes fall back to normal execution
        state_d = `SCHS_ST_RUN;
      end
    endcase
  end

  always @(posedge clock_i) begin
    if (rst_i) begin
      state_q <= `SCHS_ST_RUN;
      halt_owed_q <= 1'b0;
      inta_cnt_q <= 2'h0;
      inta_cycle_o <= 1'b0;
      desc_read_o <= 1'b0;
      isr_fetch_o <= 1'b0;
      isr_start_o <= 1'b0;
      halted_o <= 1'b0;
      stop_granted_o <= 1'b0;
    end else begin
      state_q <= state_d;
      halt_owed_q <= halt_owed_d;
      inta_cnt_q <= inta_cnt_d;
      // decoded from the next state so the outputs change at the deciding
      // edge, together with the special cycle strobe
      inta_cycle_o <= schs_in_state(state_d, `SCHS_ST_INTA);
      desc_read_o <= schs_in_state(state_d, `SCHS_ST_DESC);
      isr_fetch_o <= schs_in_state(state_d, `SCHS_ST_FETCH);
      isr_start_o <= schs_in_state(state_d, `SCHS_ST_ISR);
      halted_o <= schs_in_state(state_d, `SCHS_ST_HALTED);
      stop_granted_o <= schs_in_state(state_d, `SCHS_ST_STOPGNT);
    end
  end

  // strobe and code leave through their own flops
  schs_cycle_gen u_cyc (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .req_i(cyc_req),
    .code_i(cyc_code),
    .cyc_valid_o(special_valid_o),
    .cyc_code_o(special_code_o)
  );
endmodule

// *** verification/schs_chipset.sv ***
// system-side model: stop request and interrupt source
`timescale 1ns/1ns
module schs_chipset (
  input wire clock_i,
  output reg stop_clock_request_n_o = 1'h1,
  output reg intr_o = 1'h0
);
  // held until the system wants the core back
  task hold_stop(input on);
    @(posedge clock_i) stop_clock_request_n_o <= !on;
  endtask
  task irq(input on);
    @(posedge clock_i) intr_o <= on;
  endtask
endmodule

// *** verification/schs_sva.sv ***
// port checker for the stop-clock and halt sequencer
`timescale 1ns/1ns
`include "schs_defines.vh"
module schs_sva (
  input wire clock_i,
  input wire rst_i,
  input wire stop_clock_request_n_i,
  input wire intr_i,
  input wire int_enable_i,
  input wire inta_cycle_o,
  input wire desc_read_o,
  input wire isr_fetch_o,
  input wire isr_start_o,
  input wire halted_o,
  input wire stop_granted_o,
  input wire special_valid_o,
  input wire [`SCHS_CYC_W-1:0] special_code_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  a_grant_cycle: assert property ($rose(stop_granted_o) |->
    special_valid_o && special_code_o == `SCHS_CYC_STOPGNT) else $error("gc");
  a_halt_cycle: assert property ($rose(halted_o) |->
    special_valid_o && special_code_o == `SCHS_CYC_HALT) else $error("hc");
  a_valid_pulse: assert property (special_valid_o |=>
    !special_valid_o || $changed(special_code_o)) else $error("vp");
  a_stop_holds: assert property (stop_granted_o && !stop_clock_request_n_i
    |=> stop_granted_o && !inta_cycle_o) else $error("sh");
  a_wake_service: assert property ((halted_o || stop_granted_o) &&
    stop_clock_request_n_i && intr_i && int_enable_i |=> inta_cycle_o)
    else $error("ws");
  a_inta_cause: assert property ($rose(inta_cycle_o) |->
    $past(intr_i && stop_clock_request_n_i)) else $error("ic");
  a_desc_next: assert property ($fell(inta_cycle_o) && !$past(rst_i)
    |-> desc_read_o) else $error("dn");
  a_start_order: assert property ($rose(isr_start_o) |-> $past(isr_fetch_o))
    else $error("so");
  cover property ($rose(stop_granted_o));
  cover property ($rose(halted_o));
  cover property (isr_start_o);
endmodule
bind schs_sequencer schs_sva chk_i (.*);

// *** verification/tb_stop_clock_halt_sequencer.sv ***
// self-checking bench for the stop-clock and halt sequencer
`timescale 1ns/1ns
`include "schs_defines.vh"
module tb_stop_clock_halt_sequencer;
  reg clock_i = 1'h0;
  reg rst_i;
  reg ie, ahr, bnd, halt_instruction, management_mode_resume_instruction, rth, done;
  wire stop_n, intr, inta_cycle_o, desc_read_o, isr_fetch_o, isr_start_o;
  wire halted_o, stop_granted_o, special_valid_o;
  wire [`SCHS_CYC_W-1:0] special_code_o;
  wire [`SCHS_CYC_W:0] spec;
  assign spec = {special_valid_o, special_code_o};
  integer miscompares = 0, checked = 0, cycles = 0;
  schs_chipset cs (.clock_i, .stop_clock_request_n_o(stop_n), .intr_o(intr));
  schs_sequencer dut (.*, .stop_clock_request_n_i(stop_n), .intr_i(intr),
    .int_enable_i(ie), .auto_halt_restart_i(ahr), .insn_boundary_i(bnd),
    .halt_instruction_i(halt_instruction), .management_mode_resume_instruction_i(management_mode_resume_instruction),
    .resume_to_halt_i(rth), .bus_done_i(done));
  initial forever #4 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cycles = cycles + 1;
    if (cycles == 500) begin
      miscompares = miscompares + 1;
      results;
    end
  end
  task chk(input [31:0] nm, input [2:0] exp, input [2:0] got);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        $display("MISMATCH %0s exp %0h got %0h", nm, exp, got);
        miscompares = miscompares + 1;
      end
    end
  endtask
  task insn(input h, input r, input t);
    begin
      @(posedge clock_i) bnd <= 1'h1;
      halt_instruction <= h;
      management_mode_resume_instruction <= r;
      rth <= t;
      @(posedge clock_i) bnd <= 1'h0;
      halt_instruction <= 1'h0;
      management_mode_resume_instruction <= 1'h0;
      rth <= 1'h0;
      #1;
    end
  endtask
  task pulse;
    begin
      @(posedge clock_i) done <= 1'h1;
      @(posedge clock_i) done <= 1'h0;
      #1;
    end
  endtask
  task serve;
    begin
      cs.irq(1'h0);
      pulse;
      pulse;
      chk("desc", 3'h1, desc_read_o);
      pulse;
      chk("ftch", 3'h1, isr_fetch_o);
      pulse;
      chk("strt", 3'h1, isr_start_o);
    end
  endtask
  task t_halt;
    begin
      insn(1'h1, 1'h0, 1'h0);
      chk("halt", 3'h1, halted_o);
      chk("hcyc", {1'h1, `SCHS_CYC_HALT}, spec);
      @(posedge clock_i) ie <= 1'h0;
      cs.irq(1'h1);
      repeat (2) @(posedge clock_i);
      #1 chk("mask", 3'h2, {inta_cycle_o, halted_o, special_valid_o});
      @(posedge clock_i) ie <= 1'h1;
      @(posedge clock_i) #1 chk("inta", 3'h1, inta_cycle_o);
      serve;
    end
  endtask
  task t_stop;
    begin
      cs.hold_stop(1'h1);
      repeat (3) @(posedge clock_i);
      #1 chk("nogn", 3'h0, stop_granted_o);
      insn(1'h0, 1'h1, 1'h1);
      chk("gnt", 3'h1, stop_granted_o);
      chk("gcyc", {1'h1, `SCHS_CYC_STOPGNT}, spec);
      cs.irq(1'h1);
      repeat (4) @(posedge clock_i);
      #1 chk("hold", 3'h1, {inta_cycle_o, stop_granted_o});
      cs.hold_stop(1'h0);
      @(posedge clock_i) #1 chk("wake", 3'h2, {inta_cycle_o, special_valid_o});
      serve;
    end
  endtask
  task t_rsm;
    begin
      @(posedge clock_i) ahr <= 1'h0;
      insn(1'h0, 1'h1, 1'h1);
      chk("noah", 3'h0, halted_o);
      @(posedge clock_i) ahr <= 1'h1;
      insn(1'h0, 1'h1, 1'h0);
      chk("nort", 3'h0, halted_o);
      cs.hold_stop(1'h1);
      insn(1'h0, 1'h1, 1'h1);
      chk("rgnt", {1'h1, `SCHS_CYC_STOPGNT}, spec);
      cs.hold_stop(1'h0);
      @(posedge clock_i) #1 chk("rhlt", 3'h1, halted_o);
      chk("rcyc", {1'h1, `SCHS_CYC_HALT}, spec);
    end
  endtask
  task results;
    begin
      if (miscompares == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  initial begin
    rst_i <= 1'h1;
    ie <= 1'h1;
    ahr <= 1'h1;
    bnd <= 1'h0;
    halt_instruction <= 1'h0;
    management_mode_resume_instruction <= 1'h0;
    rth <= 1'h0;
    done <= 1'h0;
    repeat (4) @(posedge clock_i);
    rst_i <= 1'h0;
    t_halt;
    t_stop;
    t_rsm;
    results;
  end
endmodule
